// ---- rtl/pbt_top.sv ----
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module pbt_top #(
  parameter int CLK_HZ = pbt_pkg::SYS_CLK_HZ
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire pbt_pkg::pbt_apb_req_s apb_req,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 tx_almost_full,
  output logic                      tx_wr_en,
  output logic [63:0]               tx_data,
  input  wire logic                 rx_almost_empty,
  output logic                      rx_rd_en,
  input  wire logic [63:0]          rx_data,
  input  wire logic                 align_done,
  input  wire logic                 iface_clk_mon,
  output pbt_pkg::pbt_supply_s      supply_sel,
  output logic                      uart_txd
);
  import pbt_pkg::*;

  // Counts follow the clock parameter so a faster oscillator only changes CLK_HZ
  localparam int          MS_CYC_I  = (CLK_HZ / 1000 < 1) ? 1 : CLK_HZ / 1000;
  localparam logic [31:0] MS_CYC    = 32'(MS_CYC_I * GATE_MS);
  localparam int          BAUD_I    = (CLK_HZ / UART_BAUD < 1) ? 1 : CLK_HZ / UART_BAUD;
  localparam logic [15:0] BAUD_DIV  = 16'(BAUD_I);

  typedef struct packed {
    logic [31:0]                        prdata;
    logic                               pready;
    logic                               pslverr;
    logic [1:0]                         mode;
    pbt_supply_s                        supply;
    logic                               tx_wr;
    logic [63:0]                        tx_data;
    logic [14:0]                        tx_seed;
    logic                               rx_rd;
    logic                               rx_vld;
    pbt_det_e                           det;
    logic [63:0]                        ref_frame;
    logic                               ref_ok;
    logic                               align_q;
    logic [31:0]                        frames;
    logic [31:0]                        total;
    logic [CHANS-1:0][CHAN_ERR_W-1:0]   chan_err;
    logic [31:0]                        ms_cnt;
    logic [31:0]                        elapsed;
    logic                               mon_q;
    logic [31:0]                        edges;
    logic [31:0]                        freq;
    logic                               ua_busy;
    logic [8:0]                         ua_shift;
    logic [3:0]                         ua_cnt;
    logic [15:0]                        ua_div;
    logic                               ua_txd;
  } pbt_state_s;

  pbt_state_s s_r;
  pbt_state_s s_nxt;

  // Serial LFSR, newest bit lands in bit 0 so frame[14:0] is the next seed
  function automatic logic [63:0] pbt_prbs(input logic [1:0] mode, input logic [14:0] seed);
    logic [14:0] s;
    logic        b;
    logic [63:0] f;
    s = seed;
    f = '0;
    for (int i = FRAME_W - 1; i >= 0; i--) begin
      b    = (mode == MODE_PRBS7) ? (s[6] ^ s[5]) : (s[14] ^ s[13]);
      s    = {s[13:0], b};
      f[i] = b;
    end
    return f;
  endfunction

  // Reference for the frame after prev; clock patterns simply repeat
  function automatic logic [63:0] pbt_predict(input logic [1:0] mode, input logic [63:0] prev);
    logic [63:0] f;
    if (mode == MODE_PRBS7 || mode == MODE_PRBS15) begin
      f = pbt_prbs(mode, prev[14:0]);
    end else begin
      f = prev;
    end
    return f;
  endfunction

  function automatic logic [2:0] pbt_pop4(input logic [3:0] v);
    return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  // Channel counters sit in a window of their own above the scalar registers
  function automatic logic pbt_in_chan(input logic [7:0] a);
    logic h;
    h = (a >= A_CHAN_BASE) && (a < A_CHAN_BASE + 8'(4 * CHANS));
    return h;
  endfunction

  // Zero-wait slave: data and error are fixed in the setup cycle, so reads cost no stall
  function automatic logic pbt_is_setup(input pbt_apb_req_s r);
    logic t;
    t = r.psel & ~r.penable;
    return t;
  endfunction

  function automatic logic [31:0] pbt_read(input pbt_state_s st, input logic [7:0] a,
                                           input logic al);
    logic [31:0] d;
    d = '0;
    if (pbt_in_chan(a)) begin
      d = 32'(st.chan_err[4'(a[5:2])]);
    end else begin
      case (a)
        A_CTRL:    d = 32'(st.mode);
        A_SUPPLY:  d = {26'h0, st.supply.auxiliary_supply, st.supply.output_bank_supply,
                        st.supply.core_supply};
        A_STATUS:  d = {27'h0, st.ua_busy, al, st.det};
        A_FRAMES:  d = st.frames;
        A_TOTAL:   d = st.total;
        A_FREQ:    d = st.freq;
        A_ELAPSED: d = st.elapsed;
        A_UART:    d = 32'(st.ua_busy);
        default:   d = '0;
      endcase
    end
    return d;
  endfunction

  function automatic logic pbt_mapped(input logic [7:0] a);
    logic m;
    m = (a[1:0] == 2'h0) && (a <= A_UART || pbt_in_chan(a));
    return m;
  endfunction

  always_comb begin
    logic        wr;
    logic        wr_ctrl;
    logic        wr_sup;
    logic        wr_uart;
    logic        setup;
    logic [47:0] cnt_c;
    logic        restart;
    logic        det_rst;
    logic        insert;
    logic [63:0] expect_f;
    logic [63:0] diff;
    logic [6:0]  nerr;
    logic [2:0]  cerr;
    logic [14:0] csum;
    logic [32:0] tsum;
    logic        tick;
    wr       = 1'b0;
    wr_ctrl  = 1'b0;
    wr_sup   = 1'b0;
    wr_uart  = 1'b0;
    setup    = 1'b0;
    cnt_c    = '0;
    restart  = 1'b0;
    det_rst  = 1'b0;
    insert   = 1'b0;
    expect_f = '0;
    diff     = '0;
    nerr     = '0;
    cerr     = '0;
    csum     = '0;
    tsum     = '0;
    tick     = 1'b0;
    s_nxt    = s_r;

    // Zero-wait APB: read data and error prepared in the setup cycle
    setup         = pbt_is_setup(apb_req);
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup & ~pbt_mapped(apb_req.paddr);
    s_nxt.prdata  = setup ? pbt_read(s_r, apb_req.paddr, align_done) : '0;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite & s_r.pready & ~s_r.pslverr;
    wr_ctrl = wr && apb_req.paddr == A_CTRL;
    wr_sup  = wr && apb_req.paddr == A_SUPPLY;
    wr_uart = wr && apb_req.paddr == A_UART;

    if (wr_ctrl) begin
      s_nxt.mode = apb_req.pwdata[1:0];
      restart    = apb_req.pwdata[B_RESTART];
      det_rst    = apb_req.pwdata[B_DET_RST];
      insert     = apb_req.pwdata[B_INSERT];
    end
    if (wr_sup) begin
      // Applied at once and untouched by restart
      s_nxt.supply.core_supply        = apb_req.pwdata[1:0];
      s_nxt.supply.output_bank_supply = apb_req.pwdata[3:2];
      s_nxt.supply.auxiliary_supply   = apb_req.pwdata[5:4];
    end

    // Transmit: write only when there is room; the FIFO absorbs the write latency
    s_nxt.tx_wr = ~tx_almost_full;
    if (~tx_almost_full) begin
      case (s_r.mode)
        MODE_CLK1010: s_nxt.tx_data = CLK_A_WORD;
        MODE_CLK1100: s_nxt.tx_data = CLK_C_WORD;
        default: begin
          s_nxt.tx_data = pbt_prbs(s_r.mode, s_r.tx_seed);
          s_nxt.tx_seed = s_nxt.tx_data[14:0];
        end
      endcase
      if (insert) begin
        s_nxt.tx_data = ~s_nxt.tx_data;
      end
    end
    // An insert landing on a cycle without a write is simply dropped

    // Receive: data shows one cycle after the read strobe
    s_nxt.rx_rd  = ~rx_almost_empty;
    s_nxt.rx_vld = s_r.rx_rd;

    // Detector
    expect_f = pbt_predict(s_r.mode, s_r.ref_frame);
    diff     = rx_data ^ expect_f;
    // Per-channel counts are worked out once and shared by total and histogram
    for (int c = 0; c < CHANS; c++) begin
      cnt_c[3*c +: 3] = pbt_pop4(diff[4*c +: 4]);
      nerr            = nerr + 7'(cnt_c[3*c +: 3]);
    end
    case (s_r.det)
      DET_IDLE: begin
        s_nxt.det    = DET_SEARCH;
        s_nxt.ref_ok = 1'b0;
      end
      DET_SEARCH: begin
        if (s_r.rx_vld) begin
          s_nxt.ref_frame = rx_data;
          s_nxt.ref_ok    = 1'b1;
          if (s_r.ref_ok && nerr == 7'h0) begin
            s_nxt.det = DET_LOCKED;
          end
        end
      end
      DET_LOCKED, DET_BAD: begin
        if (s_r.rx_vld) begin
          // Once locked the reference free-runs so errors do not propagate
          s_nxt.ref_frame = expect_f;
          s_nxt.frames    = s_r.frames + 32'h1;
          tsum            = {1'b0, s_r.total} + 33'(nerr);
          s_nxt.total     = tsum[32] ? 32'hffffffff : tsum[31:0];
          for (int c = 0; c < CHANS; c++) begin
            cerr = cnt_c[3*c +: 3];
            csum = {1'b0, s_r.chan_err[c]} + 15'(cerr);
            s_nxt.chan_err[c] = (csum > 15'(CHAN_ERR_MAX)) ? CHAN_ERR_MAX
                                                            : csum[13:0];
          end
          if (nerr != 7'h0) begin
            s_nxt.det = (s_r.det == DET_BAD) ? DET_LOSS : DET_BAD;
          end else begin
            s_nxt.det = DET_LOCKED;
          end
        end
      end
      DET_LOSS: s_nxt.det = DET_LOSS;
      default:  s_nxt.det = DET_IDLE;
    endcase

    // Alignment finishing restarts the detectors
    s_nxt.align_q = align_done;
    if (align_done && !s_r.align_q) begin
      det_rst = 1'b1;
    end
    if (det_rst) begin
      s_nxt.det    = DET_IDLE;
      s_nxt.ref_ok = 1'b0;
    end

    // Millisecond base for elapsed time and the frequency gate
    tick = (s_r.ms_cnt >= MS_CYC - 32'h1);
    s_nxt.ms_cnt = tick ? 32'h0 : s_r.ms_cnt + 32'h1;
    if (tick) begin
      s_nxt.elapsed = s_r.elapsed + 32'h1;
    end
    // Monitor clock must be slower than half the system clock to count
    s_nxt.mon_q = iface_clk_mon;
    if (tick) begin
      s_nxt.freq  = s_r.edges;
      s_nxt.edges = {31'h0, iface_clk_mon & ~s_r.mon_q};
    end else if (iface_clk_mon && !s_r.mon_q) begin
      s_nxt.edges = s_r.edges + 32'h1;
    end

    // Byte transmitter used by the controller to ship statistics
    if (!s_r.ua_busy) begin
      if (wr_uart) begin
        s_nxt.ua_busy  = 1'b1;
        s_nxt.ua_txd   = 1'b0;
        s_nxt.ua_shift = {1'b1, apb_req.pwdata[7:0]};
        s_nxt.ua_cnt   = 4'h9;
        s_nxt.ua_div   = BAUD_DIV - 16'h1;
      end
    end else if (s_r.ua_div != 16'h0) begin
      s_nxt.ua_div = s_r.ua_div - 16'h1;
    end else if (s_r.ua_cnt == 4'h0) begin
      s_nxt.ua_busy = 1'b0;
    end else begin
      s_nxt.ua_txd   = s_r.ua_shift[0];
      s_nxt.ua_shift = {1'b1, s_r.ua_shift[8:1]};
      s_nxt.ua_cnt   = s_r.ua_cnt - 4'h1;
      s_nxt.ua_div   = BAUD_DIV - 16'h1;
    end

    // Supply survives restart; mode is reloaded from bits 1:0 of the same CTRL write, so a margin run can be repeated
    if (restart) begin
      s_nxt.tx_wr     = 1'b0;
      s_nxt.tx_seed   = TX_SEED;
      s_nxt.det       = DET_IDLE;
      s_nxt.ref_ok    = 1'b0;
      s_nxt.frames    = '0;
      s_nxt.total     = '0;
      s_nxt.chan_err  = '0;
      s_nxt.ms_cnt    = '0;
      s_nxt.elapsed   = '0;
      s_nxt.edges     = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r          <= '0;
      s_r.tx_seed  <= TX_SEED;
      s_r.det      <= DET_IDLE;
      s_r.mode     <= MODE_PRBS7;
      s_r.supply   <= '{SUP_NOMINAL, SUP_NOMINAL, SUP_NOMINAL};
      s_r.ua_shift <= 9'h1ff;
      s_r.ua_txd   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata     = s_r.prdata;
  assign pready     = s_r.pready;
  assign pslverr    = s_r.pslverr;
  assign tx_wr_en   = s_r.tx_wr;
  assign tx_data    = s_r.tx_data;
  assign rx_rd_en   = s_r.rx_rd;
  assign supply_sel = s_r.supply;
  assign uart_txd   = s_r.ua_txd;
endmodule

// ---- rtl/pbt_pkg.sv ----
// What this block does
// - Whole tester runs on one fixed system clock
// - Pattern words written to transmit FIFO
// - Received words read from receive FIFO
// - No receive reads while almost empty
// - No transmit writes while almost full
// - Timing derived from clock rate parameter
// - Restart resets counters, seed and detectors; mode and supply are kept (mode is reloaded from bits 1:0 of the same CTRL write)
// - Detectors reset when alignment completes
// - Clock patterns plus PRBS7 and PRBS15
// - Error insertion inverts one whole frame
// - Insertion without FIFO write is lost
// - Continuously measure interface clock frequency
// - Frames counted only while detector locked or in bad-frame state
// - Total bit errors and elapsed time tracked
// - Per-channel error counts saturating at 10000
// - Statistics sent over asynchronous serial link
// - Three supplies: nominal, plus, minus selects
// - Supply change immediate, no reset
// - Detector searches, matches reference, then locks
// - Bad frame state; two errored frames lose sync
// - Each FIFO frame is 64 bits
package pbt_pkg;
  localparam int          SYS_CLK_HZ   = 50_000_000;
  localparam int          UART_BAUD    = 115_200;
  localparam int          GATE_MS      = 1;
  localparam int          FRAME_W      = 64;
  localparam int          CHANS        = 16;
  localparam int          CHAN_ERR_W   = 14;
  localparam logic [13:0] CHAN_ERR_MAX = 14'h2710;
  localparam logic [14:0] TX_SEED      = 15'h7fff;
  localparam logic [7:0]  A_CTRL       = 8'h00;
  localparam logic [7:0]  A_SUPPLY     = 8'h04;
  localparam logic [7:0]  A_STATUS     = 8'h08;
  localparam logic [7:0]  A_FRAMES     = 8'h0c;
  localparam logic [7:0]  A_TOTAL      = 8'h10;
  localparam logic [7:0]  A_FREQ       = 8'h14;
  localparam logic [7:0]  A_ELAPSED    = 8'h18;
  localparam logic [7:0]  A_UART       = 8'h1c;
  localparam logic [7:0]  A_CHAN_BASE  = 8'h40;
  localparam int          B_RESTART    = 2;
  localparam int          B_DET_RST    = 3;
  localparam int          B_INSERT     = 4;
  localparam logic [1:0]  SUP_NOMINAL  = 2'h0;
  localparam logic [1:0]  SUP_PLUS     = 2'h1;
  localparam logic [1:0]  SUP_MINUS    = 2'h2;
  localparam logic [63:0] CLK_A_WORD   = 64'haaaaaaaaaaaaaaaa;
  localparam logic [63:0] CLK_C_WORD   = 64'hcccccccccccccccc;

  typedef enum logic [1:0] {
    MODE_CLK1010,
    MODE_CLK1100,
    MODE_PRBS7,
    MODE_PRBS15
  } pbt_mode_e;

  typedef enum logic [2:0] {
    DET_IDLE,
    DET_SEARCH,
    DET_LOCKED,
    DET_BAD,
    DET_LOSS
  } pbt_det_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pbt_apb_req_s;

  typedef struct packed {
    logic [1:0] core_supply;
    logic [1:0] output_bank_supply;
    logic [1:0] auxiliary_supply;
  } pbt_supply_s;
endpackage

// ---- tb/pbt_checker.sv ----
`timescale 1ns/1ps
module pbt_checker (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire pbt_pkg::pbt_apb_req_s apb_req,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  tx_almost_full,
  input wire logic                  tx_wr_en,
  input wire logic                  rx_almost_empty,
  input wire logic                  rx_rd_en,
  input wire pbt_pkg::pbt_supply_s  supply_sel
);
  import pbt_pkg::*;
  logic       sup_wr;
  logic       setup;
  logic       rst_wr;
  logic [5:0] sw;
  assign setup = apb_req.psel && !apb_req.penable;
  assign sup_wr = apb_req.psel && apb_req.penable && pready && apb_req.pwrite
                  && apb_req.paddr == A_SUPPLY;
  assign sw = {apb_req.pwdata[1:0], apb_req.pwdata[3:2], apb_req.pwdata[5:4]};
  assign rst_wr = apb_req.psel && apb_req.penable && pready && apb_req.pwrite
                  && apb_req.paddr == A_CTRL && apb_req.pwdata[B_RESTART];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_tx_full_stop: assert property (tx_almost_full |=> !tx_wr_en)
    else $error("tx write while almost full");
  a_rx_empty_stop: assert property (rx_almost_empty |=> !rx_rd_en)
    else $error("rx read while almost empty");
  a_tx_keeps_up: assert property (!tx_almost_full && !rst_wr |=> tx_wr_en)
    else $error("tx write skipped");
  a_restart_tx: assert property (rst_wr |=> !tx_wr_en)
    else $error("tx write on restart");
  a_rx_keeps_up: assert property (!rx_almost_empty |=> rx_rd_en)
    else $error("rx read skipped");
  a_apb_answer: assert property (setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  a_ready_after_setup: assert property (pready |-> $past(setup))
    else $error("pready without setup");
  a_misaligned_err: assert property (setup && apb_req.paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_supply_set: assert property (sup_wr |=> supply_sel == $past(sw))
    else $error("supply select not applied");
  a_supply_hold: assert property (!$stable(supply_sel) |-> $past(sup_wr))
    else $error("supply select changed without write");
  c_tx_stall: cover property (tx_almost_full ##1 !tx_wr_en);
  c_rx_read: cover property (!rx_almost_empty ##1 rx_rd_en);
  c_supply: cover property (sup_wr);
endmodule

bind pbt_top pbt_checker u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .pready(pready), .pslverr(pslverr), .tx_almost_full(tx_almost_full),
  .tx_wr_en(tx_wr_en), .rx_almost_empty(rx_almost_empty), .rx_rd_en(rx_rd_en),
  .supply_sel(supply_sel));

// ---- tb/pbt_far_model.sv ----
`timescale 1ns/1ps
module pbt_far_model #(
  parameter int DIV = 2
) (
  input  wire logic        pclk,
  input  wire logic        stall,
  input  wire logic        corrupt,
  input  wire logic        flush,
  input  wire logic        tx_wr_en,
  input  wire logic [63:0] tx_data,
  output logic             tx_almost_full,
  input  wire logic        rx_rd_en,
  output logic [63:0]      rx_data,
  output logic             rx_almost_empty,
  output logic             iface_clk_mon
);
  logic [63:0] txq[$];
  logic [63:0] rxq[$];
  int          ph;
  initial begin
    ph = 0;
    tx_almost_full = 1'b0;
    rx_almost_empty = 1'b1;
    rx_data = '0;
    iface_clk_mon = 1'b0;
  end
  always @(posedge pclk) begin
    if (tx_wr_en === 1'b1) txq.push_back(tx_data);
    if (rx_rd_en === 1'b1 && rxq.size() > 0) rx_data <= rxq.pop_front();
    else rx_data <= ~rx_data;
    // Divided clock toggles every DIV cycles, so it never outruns pclk
    ph = (ph + 1) % DIV;
    if (ph == 0) iface_clk_mon <= ~iface_clk_mon;
    if (ph == 0 && !iface_clk_mon && !stall && txq.size() > 0) begin
      if (corrupt) rxq.push_back(~txq.pop_front());
      else rxq.push_back(txq.pop_front());
    end
    if (flush) begin
      txq.delete();
      rxq.delete();
    end
    // Margins cover the one-cycle flag-to-strobe latency of the tester
    tx_almost_full <= txq.size() >= 12;
    rx_almost_empty <= rxq.size() < 4;
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import pbt_pkg::*;
  localparam int CLK      = 20000;
  localparam int MSC      = CLK / 1000;
  localparam int DIV      = 2;
  localparam int BDIV     = (CLK / UART_BAUD < 1) ? 1 : CLK / UART_BAUD;
  localparam int RUNS [4] = '{1, 2, 7, 15};
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  pbt_apb_req_s  req = '0;
  logic [31:0]   prdata, rd, v, e;
  logic [63:0]   tx_data, rx_data;
  logic [8:0]    rxb;
  pbt_supply_s   supply_sel;
  logic          pready, pslverr, tx_almost_full, tx_wr_en, rx_almost_empty, rx_rd_en;
  logic          iface_clk_mon, uart_txd, er, af_at, lastb;
  logic          align_done = 1'b0, stall = 1'b0, corrupt = 1'b0, flush = 1'b0;
  int            failures = 0, comparisons = 0, run = 0, maxrun = 0, ugot = 0, te, n0, x;

  always #10 pclk = ~pclk;
  pbt_top #(.CLK_HZ(CLK)) u_dut ( // timing scaled through the clock parameter
    .pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_almost_full(tx_almost_full), .tx_wr_en(tx_wr_en),
    .tx_data(tx_data), .rx_almost_empty(rx_almost_empty), .rx_rd_en(rx_rd_en),
    .rx_data(rx_data), .align_done(align_done), .iface_clk_mon(iface_clk_mon),
    .supply_sel(supply_sel), .uart_txd(uart_txd));
  pbt_far_model #(.DIV(DIV)) u_far (.pclk(pclk), .stall(stall), .corrupt(corrupt),
    .flush(flush), .tx_wr_en(tx_wr_en), .tx_data(tx_data), .tx_almost_full(tx_almost_full),
    .rx_rd_en(rx_rd_en), .rx_data(rx_data), .rx_almost_empty(rx_almost_empty),
    .iface_clk_mon(iface_clk_mon));

  // Longest run of equal bits on the transmit stream, bit 63 first
  always @(posedge pclk) if (tx_wr_en === 1'b1) begin
    for (int i = 63; i >= 0; i--) begin
      run = (tx_data[i] === lastb) ? run + 1 : 1;
      lastb = tx_data[i];
      if (run > maxrun) maxrun = run;
    end
  end
  initial forever begin
    @(posedge pclk);
    if (uart_txd === 1'b0) begin
      for (int i = 0; i < 9; i++) begin
        repeat (BDIV) @(posedge pclk);
        rxb = {uart_txd, rxb[8:1]};
      end
      ugot++;
    end
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(bit w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    check("pready wait", n, 1);
    rd = prdata;
    er = pslverr;
    af_at = tx_almost_full;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] exp);
    apb(0, a, 0);
    check(nm, rd, exp);
  endtask
  task automatic wait_n(int n);
    repeat (n) @(posedge pclk);
  endtask
  // Stalling first keeps stale frames of the old sequence out of the detector
  task automatic restart(int m);
    stall <= 1'b1;
    wait_n(30);
    apb(1, A_CTRL, 32'(m) | (32'h1 << B_RESTART));
    flush <= 1'b1;
    @(posedge pclk);
    flush <= 1'b0;
    stall <= 1'b0;
  endtask
  task automatic tell(string nm);
    $display("test %s finished", nm);
  endtask
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    test_done();
  end
  initial begin
    x = $urandom(75);
    wait_n(16);
    presetn <= 1'b1;
    align_done <= 1'b1;
    wait_n(2);
    rd_chk("mode reset", A_CTRL, 32'(MODE_PRBS7));
    rd_chk("supply reset", A_SUPPLY, 0);
    apb(0, 8'h30, 0);
    check("unmapped err", er, 1);
    check("unmapped data", rd, 0);
    apb(0, 8'h02, 0);
    check("misaligned", er, 1);
    tell("registers");
    for (int m = 0; m < 4; m++) begin
      restart(m);
      maxrun = 0;
      run = 0;
      wait_n(3000);
      rd_chk("mode", A_CTRL, m);
      check("max run", maxrun, RUNS[m]);
    end
    tell("patterns");
    restart(MODE_PRBS7);
    rd_chk("frames cleared", A_FRAMES, 0);
    rd_chk("total cleared", A_TOTAL, 0);
    wait_n(300);
    rd_chk("locked", A_STATUS, 32'h0a);
    apb(0, A_FRAMES, 0);
    check("frames", rd != 0, 1);
    tell("lock");
    te = 0;
    for (int k = 0; k < 6; k++) begin
      stall <= k[0];
      wait_n(20 + $urandom % 20);
      apb(1, A_CTRL, MODE_PRBS7 | (32'h1 << B_INSERT));
      if (!af_at) te += 64;
      stall <= 1'b0;
      wait_n(60);
    end
    rd_chk("total errors", A_TOTAL, te);
    rd_chk("chan errors", A_CHAN_BASE + 8'(4 * ($urandom % 16)), te / 16);
    rd_chk("relocked", A_STATUS, 32'h0a);
    tell("insert");
    for (int k = 0; k < 2; k++) begin
      corrupt <= 1'b1;
      wait_n(60);
      corrupt <= 1'b0;
      wait_n(60);
      rd_chk("sync loss", A_STATUS, 32'h0c);
      if (k == 0) apb(1, A_CTRL, MODE_PRBS7 | (32'h1 << B_DET_RST));
      else begin
        align_done <= 1'b0;
        wait_n(5);
        align_done <= 1'b1;
      end
      wait_n(300);
      rd_chk("recovered", A_STATUS, 32'h0a);
    end
    tell("sync loss");
    for (int k = 0; k < 4; k++) begin
      v = ($urandom % 3) | (($urandom % 3) << 2) | (($urandom % 3) << 4);
      apb(1, A_SUPPLY, v);
      check("supply pins", supply_sel, {v[1:0], v[3:2], v[5:4]});
      rd_chk("supply read", A_SUPPLY, v);
    end
    rd_chk("still locked", A_STATUS, 32'h0a);
    tell("supply");
    apb(0, A_FREQ, 0);
    check("freq", rd >= MSC / (2 * DIV) - 1 && rd <= MSC / (2 * DIV) + 1, 1);
    apb(0, A_ELAPSED, 0);
    e = rd;
    wait_n(10 * MSC);
    apb(0, A_ELAPSED, 0);
    check("elapsed", rd - e >= 9 && rd - e <= 11, 1);
    tell("measure");
    v = $urandom % 256;
    n0 = ugot;
    apb(1, A_UART, v);
    rd_chk("uart busy", A_UART, 1);
    wait_n(12 * BDIV);
    check("uart frames", ugot - n0, 1);
    check("uart byte", rxb, {1'b1, v[7:0]});
    rd_chk("uart idle", A_UART, 0);
    tell("uart");
    test_done();
  end
endmodule
